// ===== include/clc_pkg.sv
// constants for the configurable logic cell control block
// shared by the design module and the bench; no other dependency
package clc_pkg;
  localparam int CLC_CELLS_DEF  = 4;
  localparam int CLC_IN_SEL_W   = 6;
  localparam int CLC_IN_NUM     = 64;
  localparam int CLC_GATES      = 4;
  localparam int CLC_GLS_W      = 8;
  localparam int CLC_FUNC_W     = 3;
  localparam logic [2:0] FN_AND_OR   = 3'h0;
  localparam logic [2:0] FN_OR_XOR   = 3'h1;
  localparam logic [2:0] FN_AND4     = 3'h2;
  localparam logic [2:0] FN_SR_LATCH = 3'h3;
  localparam logic [2:0] FN_DFF_SR   = 3'h4;
  localparam logic [2:0] FN_DFF2     = 3'h5;
  localparam logic [2:0] FN_JK       = 3'h6;
  localparam logic [2:0] FN_DLATCH   = 3'h7;
  localparam logic [2:0] CTRL_FUNC_RST = 3'h0;
  localparam logic       CTRL_BIT_RST  = 1'h0;
endpackage

// ===== src/clc_ctrl.sv
// configurable logic cell control: input select, gates, function, edge
// flags, output mirror. assumes control ports from same clock domain and
// cell input sources from outside, synchronised here.
`timescale 1ns/1ps
module clc_ctrl
  import clc_pkg::*;
#(
  parameter int CELLS   = CLC_CELLS_DEF,
  parameter int OSC_SEL = 1
) (
  input  wire logic                          I_SYS_CLK,
  input  wire logic                          I_RST_B,
  input  wire logic [CLC_IN_NUM-1:0]         I_SRC,
  input  wire logic                          I_SLEEP,
  input  wire logic [CELLS-1:0]              I_CELL_ENABLE_BIT,
  input  wire logic [CELLS-1:0]              I_RISING_EDGE_IRQ_ENABLE,
  input  wire logic [CELLS-1:0]              I_FALLING_EDGE_IRQ_ENABLE,
  input  wire logic [CELLS*CLC_FUNC_W-1:0]   I_LOGIC_FUNCTION_FIELD,
  input  wire logic [CELLS-1:0]              I_CTRL_WE,
  input  wire logic [CELLS*4*CLC_IN_SEL_W-1:0] I_INPUT_SELECT,
  input  wire logic [CELLS*4*CLC_GLS_W-1:0]  I_GATE_SELECT,
  input  wire logic [CELLS*4-1:0]            I_GATE_POLARITY_BIT,
  input  wire logic [CELLS-1:0]              I_OUTPUT_POLARITY_BIT,
  input  wire logic [CELLS-1:0]              I_SEL_WE,
  input  wire logic [CELLS-1:0]              I_FLAG_CLR,
  output logic      [CELLS-1:0]              O_CELL_INTERRUPT_FLAG,
  output logic      [CELLS-1:0]              O_CELL_OUTPUT_BIT,
  output logic      [CELLS-1:0]              O_CELL_OUTPUT_MIRROR_REG,
  output logic      [CELLS-1:0]              O_CELL_ENABLE_STATUS,
  output logic                               O_FAST_OSC_KEEP
);
  // refuse sizes the flat port packing and loops cannot serve
  if (CELLS < 1 || CELLS > 8) begin : g_bad_cells
    $error("CELLS must be 1..8");
  end
  if (OSC_SEL < 0 || OSC_SEL >= CLC_IN_NUM) begin : g_bad_osc
    $error("OSC_SEL range");
  end

  // sources come from other domains; two flops before any logic
  logic [CLC_IN_NUM-1:0] src_s1_reg, src_s2_reg;
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      src_s1_reg <= '0;
      src_s2_reg <= '0;
    end else begin
      src_s1_reg <= I_SRC;
      src_s2_reg <= src_s1_reg;
    end
  end

  // control: cleared by reset
  logic [CELLS-1:0]            en_reg, en_next;
  logic [CELLS-1:0]            rie_reg, rie_next, fie_reg, fie_next;
  logic [CELLS*CLC_FUNC_W-1:0] fn_reg, fn_next;
  always_comb begin
    en_next  = en_reg;
    rie_next = rie_reg;
    fie_next = fie_reg;
    fn_next  = fn_reg;
    for (int c = 0; c < CELLS; c++) begin
      if (I_CTRL_WE[c]) begin
        en_next[c]  = I_CELL_ENABLE_BIT[c];
        rie_next[c] = I_RISING_EDGE_IRQ_ENABLE[c];
        fie_next[c] = I_FALLING_EDGE_IRQ_ENABLE[c];
        fn_next[c*CLC_FUNC_W +: CLC_FUNC_W] =
          I_LOGIC_FUNCTION_FIELD[c*CLC_FUNC_W +: CLC_FUNC_W];
      end
    end
  end
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      en_reg  <= {CELLS{CTRL_BIT_RST}};
      rie_reg <= {CELLS{CTRL_BIT_RST}};
      fie_reg <= {CELLS{CTRL_BIT_RST}};
      fn_reg  <= {CELLS{CTRL_FUNC_RST}};
    end else begin
      en_reg  <= en_next;
      rie_reg <= rie_next;
      fie_reg <= fie_next;
      fn_reg  <= fn_next;
    end
  end

  // selections: no reset at all, so they survive any reset
  logic [CELLS*4*CLC_IN_SEL_W-1:0] sel_reg, sel_next;
  logic [CELLS*4*CLC_GLS_W-1:0]    gls_reg, gls_next;
  logic [CELLS*4-1:0]              gpol_reg, gpol_next;
  logic [CELLS-1:0]                opol_reg, opol_next;
  always_comb begin
    sel_next  = sel_reg;
    gls_next  = gls_reg;
    gpol_next = gpol_reg;
    opol_next = opol_reg;
    for (int c = 0; c < CELLS; c++) begin
      if (I_SEL_WE[c]) begin
        sel_next[c*4*CLC_IN_SEL_W +: 4*CLC_IN_SEL_W] =
          I_INPUT_SELECT[c*4*CLC_IN_SEL_W +: 4*CLC_IN_SEL_W];
        gls_next[c*4*CLC_GLS_W +: 4*CLC_GLS_W] =
          I_GATE_SELECT[c*4*CLC_GLS_W +: 4*CLC_GLS_W];
        gpol_next[c*4 +: 4] = I_GATE_POLARITY_BIT[c*4 +: 4];
        opol_next[c] = I_OUTPUT_POLARITY_BIT[c];
      end
    end
  end
  always_ff @(posedge I_SYS_CLK) begin
    sel_reg  <= sel_next;
    gls_reg  <= gls_next;
    gpol_reg <= gpol_next;
    opol_reg <= opol_next;
  end

  // gate g: OR of enabled true/inverted data lines, then polarity
  function automatic logic gate_f(input logic [3:0] d,
                                  input logic [CLC_GLS_W-1:0] s,
                                  input logic pol);
    logic acc;
    acc = 1'b0;
    for (int k = 0; k < 4; k++) begin
      acc = acc | (s[2*k] & ~d[k]) | (s[2*k+1] & d[k]);
    end
    return acc ^ pol;
  endfunction

  // cell state for latch/flop modes, clocked here since no other clock
  logic [CELLS-1:0] q_reg, q_next, out_reg, out_next;
  logic [CELLS-1:0] prev_reg, prev_next, flag_reg, flag_next;
  logic [CELLS-1:0] mir_reg, mir_next;
  logic             osc_reg, osc_next;
  always_comb begin
    logic [3:0] d;
    logic [3:0] g;
    logic       f;
    logic       rise;
    logic       fall;
    d = '0;
    g = '0;
    f = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    q_next    = q_reg;
    out_next  = out_reg;
    prev_next = prev_reg;
    flag_next = flag_reg;
    osc_next  = 1'b0;
    for (int c = 0; c < CELLS; c++) begin
      for (int k = 0; k < 4; k++) begin
        d[k] = src_s2_reg[sel_reg[(c*4+k)*CLC_IN_SEL_W +: CLC_IN_SEL_W]];
        if (en_reg[c] &&
            sel_reg[(c*4+k)*CLC_IN_SEL_W +: CLC_IN_SEL_W] ==
            CLC_IN_SEL_W'(OSC_SEL))
          osc_next = 1'b1;
      end
      for (int k = 0; k < 4; k++) begin
        g[k] = gate_f(d, gls_reg[(c*4+k)*CLC_GLS_W +: CLC_GLS_W],
                      gpol_reg[c*4+k]);
      end
      case (fn_reg[c*CLC_FUNC_W +: CLC_FUNC_W])
        FN_AND_OR:   f = (g[0] & g[1]) | (g[2] & g[3]);
        FN_OR_XOR:   f = (g[0] | g[1]) ^ (g[2] | g[3]);
        FN_AND4:     f = &g;
        FN_SR_LATCH: begin
          if (g[2] | g[3]) q_next[c] = 1'b0;
          else if (g[0] | g[1]) q_next[c] = 1'b1;
          f = q_next[c];
        end
        FN_DFF_SR: begin
          if (g[3]) q_next[c] = 1'b0;
          else if (g[2]) q_next[c] = 1'b1;
          else if (g[0]) q_next[c] = g[1];
          f = q_reg[c];
        end
        FN_DFF2: begin
          if (g[2]) q_next[c] = 1'b0;
          else if (g[0]) q_next[c] = g[1] & g[3];
          f = q_reg[c];
        end
        FN_JK: begin
          if (g[2]) q_next[c] = 1'b0;
          else if (g[0]) q_next[c] = (g[1] & ~q_reg[c]) | (~g[3] & q_reg[c]);
          f = q_reg[c];
        end
        FN_DLATCH: begin
          if (g[2]) q_next[c] = 1'b0;
          else if (g[3]) q_next[c] = 1'b1;
          else if (g[0]) q_next[c] = g[1];
          f = q_next[c];
        end
        default: f = 1'b0;
      endcase
      // sleep does not stop the cell; only the enable does
      out_next[c] = en_reg[c] ? (f ^ opol_reg[c]) : 1'b0;
      prev_next[c] = out_reg[c];
      rise = out_reg[c] & ~prev_reg[c];
      fall = ~out_reg[c] & prev_reg[c];
      // set beats clear in the same cycle
      if ((rise & rie_reg[c]) | (fall & fie_reg[c]))
        flag_next[c] = 1'b1;
      else if (I_FLAG_CLR[c])
        flag_next[c] = 1'b0;
    end
    mir_next = out_next;                           // one-cycle snapshot
  end
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      q_reg    <= '0;
      out_reg  <= '0;
      prev_reg <= '0;
      flag_reg <= '0;
      mir_reg  <= '0;
      osc_reg  <= 1'b0;
    end else begin
      q_reg    <= q_next;
      out_reg  <= out_next;
      prev_reg <= prev_next;
      flag_reg <= flag_next;
      mir_reg  <= mir_next;
      osc_reg  <= osc_next;
    end
  end

  always_comb begin
    O_CELL_OUTPUT_BIT        = out_reg;
    O_CELL_OUTPUT_MIRROR_REG = mir_reg;   // same flop source
    O_CELL_INTERRUPT_FLAG    = flag_reg;
    O_CELL_ENABLE_STATUS     = en_reg;
    O_FAST_OSC_KEEP          = osc_reg;
  end

  logic [3:0] g_dbg;

  AST_RISE_SETS_FLAG: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_B)
    (out_reg & ~prev_reg & rie_reg) != '0 |=>
      (flag_reg & $past(out_reg & ~prev_reg & rie_reg)) ==
      $past(out_reg & ~prev_reg & rie_reg))
    else $error("rising edge did not set flag");
  AST_FALL_SETS_FLAG: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_B)
    (~out_reg & prev_reg & fie_reg) != '0 |=>
      (flag_reg & $past(~out_reg & prev_reg & fie_reg)) ==
      $past(~out_reg & prev_reg & fie_reg))
    else $error("falling edge did not set flag");
  AST_NO_SPURIOUS_FLAG: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_B)
    $rose(flag_reg[0]) |->
      $past((out_reg[0] & ~prev_reg[0] & rie_reg[0]) |
            (~out_reg[0] & prev_reg[0] & fie_reg[0])))
    else $error("flag set without enabled edge");
  AST_CLEAR_WORKS: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_B)
    I_FLAG_CLR[0] && !((out_reg[0] & ~prev_reg[0] & rie_reg[0]) |
      (~out_reg[0] & prev_reg[0] & fie_reg[0])) |=> !flag_reg[0])
    else $error("flag clear ignored");
  AST_MIRROR_MATCH: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_B) mir_reg == out_reg)
    else $error("mirror differs from output bits");
  AST_MIRROR_FOLLOWS: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_B) ##1 prev_reg == $past(mir_reg))
    else $error("mirror not a single snapshot");
  AST_DISABLED_LOW: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_B) !en_reg[0] |=> !out_reg[0])
    else $error("disabled cell output not low");
  AST_SLEEP_RUNS: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_B)
    I_SLEEP && en_reg[0] && fn_reg[2:0] == FN_AND4 && !I_CTRL_WE[0]
      && !I_SEL_WE[0] |=> out_reg[0] == $past(&g_dbg ^ opol_reg[0]))
    else $error("cell stopped in sleep");
  AST_OSC_KEEP: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_B)
    en_reg[0] && sel_reg[3*CLC_IN_SEL_W +: CLC_IN_SEL_W] ==
      CLC_IN_SEL_W'(OSC_SEL) |=> O_FAST_OSC_KEEP)
    else $error("fast oscillator request dropped");
  AST_FLAG_HOLDS: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_B) flag_reg[0] && !I_FLAG_CLR[0] |=> flag_reg[0])
    else $error("flag dropped without clear");
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      g_dbg[k] = gate_f({src_s2_reg[sel_reg[3*CLC_IN_SEL_W +: CLC_IN_SEL_W]],
        src_s2_reg[sel_reg[2*CLC_IN_SEL_W +: CLC_IN_SEL_W]],
        src_s2_reg[sel_reg[1*CLC_IN_SEL_W +: CLC_IN_SEL_W]],
        src_s2_reg[sel_reg[0 +: CLC_IN_SEL_W]]},
        gls_reg[k*CLC_GLS_W +: CLC_GLS_W], gpol_reg[k]);
    end
  end
endmodule

// ===== verification/configurable_logic_cell_control_bench.sv
// self-checking bench for the logic cell control block
// drives all ports itself; cells run the and4 function for expectations, except cell 1 in its sweep over all eight function codes
`timescale 1ns/1ps
module configurable_logic_cell_control_bench
  import clc_pkg::*;
;
  localparam int NC  = 4;
  localparam int OSC = 1;
  logic         clk      = 1'b0;
  logic         rst_b    = 1'b0;
  logic         sleep    = 1'b0;
  logic [63:0]  src      = 64'h0;
  logic [3:0]   en       = 4'h0;
  logic [3:0]   rie      = 4'h0;
  logic [3:0]   fie      = 4'h0;
  logic [3:0]   cwe      = 4'h0;
  logic [3:0]   swe      = 4'h0;
  logic [3:0]   clr      = 4'h0;
  logic [3:0]   opol     = 4'h0;
  logic [11:0]  fn       = 12'h0;
  logic [95:0]  isel     = 96'h0;
  logic [127:0] gsel     = {4{32'h00000002}};
  logic [15:0]  gpol     = {4{4'hE}};
  logic [3:0]   flag;
  logic [3:0]   outb;
  logic [3:0]   mir;
  logic [3:0]   stat;
  logic         keep;
  logic [31:0]  seed     = 32'h49F5D0DB;
  int           fails    = 0;
  int           samples_checked = 0;

  always #25 clk = ~clk;

  clc_ctrl #(.CELLS(NC), .OSC_SEL(OSC)) uut (
    .I_SYS_CLK                (clk),
    .I_RST_B                  (rst_b),
    .I_SRC                    (src),
    .I_SLEEP                  (sleep),
    .I_CELL_ENABLE_BIT        (en),
    .I_RISING_EDGE_IRQ_ENABLE (rie),
    .I_FALLING_EDGE_IRQ_ENABLE(fie),
    .I_LOGIC_FUNCTION_FIELD   (fn),
    .I_CTRL_WE                (cwe),
    .I_INPUT_SELECT           (isel),
    .I_GATE_SELECT            (gsel),
    .I_GATE_POLARITY_BIT      (gpol),
    .I_OUTPUT_POLARITY_BIT    (opol),
    .I_SEL_WE                 (swe),
    .I_FLAG_CLR               (clr),
    .O_CELL_INTERRUPT_FLAG    (flag),
    .O_CELL_OUTPUT_BIT        (outb),
    .O_CELL_OUTPUT_MIRROR_REG (mir),
    .O_CELL_ENABLE_STATUS     (stat),
    .O_FAST_OSC_KEEP          (keep)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // gate 0 passes data 0 with its own polarity, gates 1..3 forced to 1
  function automatic logic [3:0] exp_out();
    for (int c = 0; c < NC; c++) begin
      exp_out[c] = en[c] & (src[isel[c*24 +: 6]] ^ gpol[c*4] ^ opol[c]);
    end
  endfunction

  // cell 1 value per function code with gates 1..3 held high
  function automatic logic exp_fn(input int f);
    logic d0;
    d0 = src[isel[24 +: 6]] ^ gpol[4];
    case (f)
      0: exp_fn = 1'b1;
      2: exp_fn = d0;
      default: exp_fn = 1'b0;
    endcase
    exp_fn = exp_fn ^ opol[1];
  endfunction

  function automatic logic exp_keep();
    exp_keep = 1'b0;
    for (int j = 0; j < 16; j++) begin
      if (en[j/4] && isel[j*6 +: 6] == 6'(OSC)) exp_keep = 1'b1;
    end
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_ctrl(input int c, input logic e, input logic ri,
                         input logic fa, input logic [2:0] f);
    @(posedge clk);
    en[c] <= e;
    rie[c] <= ri;
    fie[c] <= fa;
    fn[c*3 +: 3] <= f;
    cwe <= 4'(1 << c);
    @(posedge clk);
    cwe <= 4'h0;
  endtask

  // slot 3 often picks the oscillator so the keep request gets exercised
  task automatic wr_sel(input int c, input logic [31:0] s);
    @(posedge clk);
    isel[c*24 +: 24] <= {s[30] ? 6'(OSC) : s[23:18], s[17:0]};
    opol[c] <= s[31];
    gpol[c*4] <= s[29];
    swe <= 4'(1 << c);
    @(posedge clk);
    swe <= 4'h0;
  endtask

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    step(20000);
    fails++;
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    logic [3:0]  prev;
    int          c;
    step(20);
    chk({flag, outb, mir, stat, keep}, 32'h0);
    rst_b <= 1'b1;
    for (c = 0; c < NC; c++) wr_sel(c, xs());
    for (c = 0; c < NC; c++) wr_ctrl(c, 1'b1, 1'b1, 1'b1, FN_AND4);
    for (int f = 0; f < 8; f++) begin
      wr_ctrl(1, 1'b1, 1'b0, 1'b0, 3'(f));
      step(6);
      chk(mir, outb);
      chk(outb[1], exp_fn(f));
    end
    wr_ctrl(1, 1'b1, 1'b1, 1'b1, FN_AND4);
    for (int d = 1; d <= 6; d++) begin
      int   k;
      logic o;
      k = 99;
      step(6);
      o = outb[0];
      @(posedge clk);
      src[isel[5:0]] <= ~src[isel[5:0]];
      for (int n = 1; n <= 8; n++) begin
        @(posedge clk);
        clr <= (n == d) ? 4'h1 : 4'h0;
        #1 if (k == 99 && outb[0] !== o) k = n;
      end
      chk(flag[0], d <= k);
    end
    for (int i = 0; i < 60; i++) begin
      r = xs();
      c = int'(r[1:0]);
      if (r[2]) begin
        wr_ctrl(c, 1'b0, r[4], r[5], FN_AND4);
        wr_sel(c, xs());
      end
      wr_ctrl(c, r[3] | r[7], r[4], r[5], FN_AND4);
      step(6);
      @(posedge clk);
      clr <= 4'hF;
      @(posedge clk);
      clr <= 4'h0;
      step(3);
      chk(flag, 4'h0);
      prev = exp_out();
      @(posedge clk);
      src <= {xs(), xs()};
      sleep <= r[8];
      step(6);
      chk(outb, exp_out());
      chk(mir, exp_out());
      chk(flag, (~prev & exp_out() & rie) |
                (prev & ~exp_out() & fie));
      chk({stat, keep}, {en, exp_keep()});
    end
    @(posedge clk);
    rst_b <= 1'b0;
    en <= 4'h0;
    src <= {xs(), xs()};
    step(3);
    chk({flag, outb, mir, stat, keep}, 32'h0);
    rst_b <= 1'b1;
    for (c = 0; c < NC; c++) wr_ctrl(c, 1'b1, 1'b0, 1'b0, FN_AND4);
    step(6);
    chk(outb, exp_out());
    report_and_stop();
  end
endmodule
